/* wpg_gate.sv */
// write permission and active/standby gating for the serial memory device
// assumes a protocol engine on clk that presents write requests and an
// address-match pulse; scl, sda and wp pins arrive asynchronously
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - nv write only with whole frames before stop
// - locks refuse wiper writes; nv needs wp low
// - wp high refuses eeprom; else outside lock region
// - ctrl volatile always; ctrl nv needs wp low
// - start wakes; mismatch sleeps nine clocks later
// - standby 200ns after non-launching stop
// - launching stop keeps active through write time
// - every write refused unless enable latch set
// - lock bits select protected eeprom region
module wpg_gate
#(
  parameter int unsigned NV_WRITE_CYCLES = wpg_pkg::NV_WRITE_CYCLES
)
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  scl_pin,
  input  wire logic                  sda_pin,
  input  wire logic                  wp_pin,
  input  wire logic                  addr_match,
  input  wire logic                  req_valid,
  input  wire wpg_pkg::wpg_kind_type req_kind,
  input  wire logic [7:0]            req_addr,
  input  wire logic [7:0]            req_data,
  output var  logic                  req_grant_r,
  output var  logic                  req_refuse_r,
  output var  logic                  active_r,
  output var  logic                  hv_start_r,
  output var  logic                  hv_busy_r,
  output var  logic                  wel_r,
  output var  logic [1:0]            lock_r,
  input  wire logic [3:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  output var  logic [31:0]           avs_readdata,
  output var  logic                  avs_waitrequest
);

  typedef enum logic [2:0] {
    ST_STANDBY,
    ST_ADDR,
    ST_SELECTED,
    ST_LINGER,
    ST_HV
  } wpg_state_type;

  localparam logic [wpg_pkg::TIMER_W-1:0] HV_LOAD =
    wpg_pkg::TIMER_W'(NV_WRITE_CYCLES - 1);
  localparam logic [wpg_pkg::TIMER_W-1:0] LINGER_LOAD =
    wpg_pkg::TIMER_W'(wpg_pkg::STOP_IDLE_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and start/stop detection

  logic scl_s;
  logic sda_s;
  logic wp_s;
  logic scl_prev_r;
  logic sda_prev_r;
  logic start_det;
  logic stop_det;
  logic scl_rise;

  wpg_sync u_sync_scl (.clk(clk), .rst(rst), .din(scl_pin), .dout(scl_s));
  wpg_sync u_sync_sda (.clk(clk), .rst(rst), .din(sda_pin), .dout(sda_s));
  wpg_sync u_sync_wp  (.clk(clk), .rst(rst), .din(wp_pin),  .dout(wp_s));

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      scl_prev_r <= 1'b0;
      sda_prev_r <= 1'b0;
    end
    else
    begin
      scl_prev_r <= scl_s;
      sda_prev_r <= sda_s;
    end
  end

  assign start_det = scl_s && scl_prev_r && sda_prev_r && !sda_s;
  assign stop_det  = scl_s && scl_prev_r && !sda_prev_r && sda_s;
  assign scl_rise  = scl_s && !scl_prev_r;

  ////////////////////////////////////////////////////////////////////////////
  // permission decision

  logic wp_smp_r;
  logic wp_smp_nxt;
  logic nv_pend_r;
  logic nv_pend_nxt;
  logic refused_r;
  logic refused_nxt;
  logic grant_nxt;
  logic refuse_nxt;
  logic in_lock;
  logic allow;
  logic is_nv;
  logic wel_nxt;
  logic [1:0] lock_nxt;
  logic bus_ctrl_wr;

  always_comb
  begin
    unique case (lock_r)
      2'b00: in_lock = 1'b0;
      2'b01: in_lock = req_addr >= wpg_pkg::LOCK_QUARTER_BASE;
      2'b10: in_lock = req_addr >= wpg_pkg::LOCK_HALF_BASE;
      2'b11: in_lock = 1'b1;
    endcase
    unique case (req_kind)
      wpg_pkg::WPG_WIPER_VOL: allow = lock_r == 2'b00;
      wpg_pkg::WPG_WIPER_NV:  allow = lock_r == 2'b00 && !wp_smp_r;
      wpg_pkg::WPG_EEPROM:    allow = !wp_smp_r && !in_lock;
      wpg_pkg::WPG_CTRL_VOL:  allow = 1'b1;
      wpg_pkg::WPG_CTRL_NV:   allow = !wp_smp_r;
      default:                allow = 1'b0;
    endcase
    is_nv = req_kind == wpg_pkg::WPG_WIPER_NV || req_kind == wpg_pkg::WPG_EEPROM
            || req_kind == wpg_pkg::WPG_CTRL_NV;
    grant_nxt  = req_valid && wel_r && allow;
    refuse_nxt = req_valid && !(wel_r && allow);
    // wp level captured once per transaction, at the address match
    wp_smp_nxt = addr_match ? wp_s : wp_smp_r;
    refused_nxt = refuse_nxt ? 1'b1 : (grant_nxt ? 1'b0 : refused_r);
    nv_pend_nxt = nv_pend_r;
    if (start_det)
      nv_pend_nxt = 1'b0;
    if (grant_nxt && is_nv)
      nv_pend_nxt = 1'b1;
    bus_ctrl_wr = avs_write && !avs_waitrequest && avs_address == wpg_pkg::REG_CTRL_ADDR;
    wel_nxt  = wel_r;
    lock_nxt = lock_r;
    // a granted volatile control write sets wel over a bus write in the same cycle; lock keeps the bus value
    if (bus_ctrl_wr)
    begin
      wel_nxt  = avs_writedata[wpg_pkg::CTRL_WEL_BIT];
      lock_nxt = avs_writedata[wpg_pkg::CTRL_LOCK_HI:wpg_pkg::CTRL_LOCK_LO];
    end
    if (grant_nxt && req_kind == wpg_pkg::WPG_CTRL_VOL)
      wel_nxt = req_data[wpg_pkg::CTRL_WEL_BIT];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wp_smp_r     <= 1'b0;
      nv_pend_r    <= 1'b0;
      refused_r    <= 1'b0;
      req_grant_r  <= 1'b0;
      req_refuse_r <= 1'b0;
      wel_r        <= wpg_pkg::CTRL_RESET[wpg_pkg::CTRL_WEL_BIT];
      lock_r       <= wpg_pkg::CTRL_RESET[wpg_pkg::CTRL_LOCK_HI:wpg_pkg::CTRL_LOCK_LO];
    end
    else
    begin
      wp_smp_r     <= wp_smp_nxt;
      nv_pend_r    <= nv_pend_nxt;
      refused_r    <= refused_nxt;
      req_grant_r  <= grant_nxt;
      req_refuse_r <= refuse_nxt;
      wel_r        <= wel_nxt;
      lock_r       <= lock_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // active / standby sequencing

  wpg_state_type state_r;
  wpg_state_type state_nxt;
  logic [3:0] clk_cnt_r;
  logic [3:0] clk_cnt_nxt;
  logic [3:0] bit_mod_r;
  logic [3:0] bit_mod_nxt;
  logic [wpg_pkg::TIMER_W-1:0] timer_r;
  logic [wpg_pkg::TIMER_W-1:0] timer_nxt;
  logic hv_start_nxt;
  logic frame_ok;

  always_comb
  begin
    state_nxt    = state_r;
    clk_cnt_nxt  = clk_cnt_r;
    bit_mod_nxt  = bit_mod_r;
    timer_nxt    = timer_r;
    hv_start_nxt = 1'b0;
    // the stop's own scl rise lands one past a byte-plus-ack boundary,
    // so a clean frame shows a remainder of one at the stop
    frame_ok = nv_pend_r && bit_mod_r == 4'h1;
    if (scl_rise)
    begin
      if (clk_cnt_r != wpg_pkg::ADDR_PHASE_CLOCKS)
        clk_cnt_nxt = clk_cnt_r + 4'h1;
      bit_mod_nxt = (bit_mod_r == wpg_pkg::BITS_PER_FRAME - 4'h1) ? 4'h0 : bit_mod_r + 4'h1;
    end
    if (timer_r != '0)
      timer_nxt = timer_r - wpg_pkg::TIMER_W'(1);
    unique case (state_r)
      ST_STANDBY, ST_LINGER, ST_ADDR, ST_SELECTED:
      begin
        if (state_r == ST_LINGER && timer_r == '0)
          state_nxt = ST_STANDBY;
        if (state_r == ST_ADDR && addr_match)
          state_nxt = ST_SELECTED;
        else if (state_r == ST_ADDR && clk_cnt_r == wpg_pkg::ADDR_PHASE_CLOCKS)
          state_nxt = ST_STANDBY;
        if ((state_r == ST_ADDR || state_r == ST_SELECTED) && stop_det)
        begin
          if (frame_ok)
          begin
            state_nxt    = ST_HV;
            timer_nxt    = HV_LOAD;
            hv_start_nxt = 1'b1;
          end
          else
          begin
            state_nxt = ST_LINGER;
            timer_nxt = LINGER_LOAD;
          end
        end
        if (start_det)
        begin
          state_nxt   = ST_ADDR;
          clk_cnt_nxt = 4'h0;
          bit_mod_nxt = 4'h0;
        end
      end
      ST_HV:
      begin
        // bus traffic is ignored until the internal write ends
        if (timer_r == '0)
          state_nxt = ST_STANDBY;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_r    <= ST_STANDBY;
      clk_cnt_r  <= 4'h0;
      bit_mod_r  <= 4'h0;
      timer_r    <= '0;
      hv_start_r <= 1'b0;
      hv_busy_r  <= 1'b0;
      active_r   <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      clk_cnt_r  <= clk_cnt_nxt;
      bit_mod_r  <= bit_mod_nxt;
      timer_r    <= timer_nxt;
      hv_start_r <= hv_start_nxt;
      hv_busy_r  <= state_nxt == ST_HV;
      active_r   <= state_nxt != ST_STANDBY;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, then answer

  logic        wait_nxt;
  logic [31:0] rdata_nxt;

  always_comb
  begin
    wait_nxt  = 1'b1;
    rdata_nxt = avs_readdata;
    if ((avs_read || avs_write) && avs_waitrequest)
    begin
      wait_nxt  = 1'b0;
      rdata_nxt = 32'h0;
      if (avs_read && avs_address == wpg_pkg::REG_CTRL_ADDR)
      begin
        rdata_nxt[wpg_pkg::CTRL_WEL_BIT] = wel_r;
        rdata_nxt[wpg_pkg::CTRL_LOCK_HI:wpg_pkg::CTRL_LOCK_LO] = lock_r;
      end
      else if (avs_read && avs_address == wpg_pkg::REG_STATUS_ADDR)
      begin
        rdata_nxt[wpg_pkg::STAT_ACTIVE_BIT]  = active_r;
        rdata_nxt[wpg_pkg::STAT_HV_BIT]      = hv_busy_r;
        rdata_nxt[wpg_pkg::STAT_WP_BIT]      = wp_smp_r;
        rdata_nxt[wpg_pkg::STAT_REFUSED_BIT] = refused_r;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end
    else
    begin
      avs_waitrequest <= wait_nxt;
      avs_readdata    <= rdata_nxt;
    end
  end

endmodule

`default_nettype wire

/* wpg_sync.sv */
// wpg_pkg: shared constants for the write permission gate
// wpg_sync: two-stage synchroniser for pins from outside the clk domain
// assumes clk at 125 MHz and an asynchronous active-high reset
`timescale 1ns/100ps
`default_nettype none

package wpg_pkg;
  // clock and timing
  localparam int unsigned CLK_PERIOD_NS    = 8;
  localparam int unsigned CLK_MHZ          = 125;
  localparam int unsigned STOP_IDLE_NS     = 200;
  localparam int unsigned STOP_IDLE_CYCLES = (STOP_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned NV_WRITE_TIME_MS = 10;
  localparam int unsigned NV_WRITE_CYCLES  = NV_WRITE_TIME_MS * 1000 * CLK_MHZ;
  localparam int unsigned TIMER_W          = 21;
  // two-wire framing
  localparam logic [3:0] ADDR_PHASE_CLOCKS = 4'h9;
  localparam logic [3:0] BITS_PER_FRAME    = 4'h9;
  // lock region thresholds
  localparam logic [7:0] LOCK_QUARTER_BASE = 8'hc0;
  localparam logic [7:0] LOCK_HALF_BASE    = 8'h80;
  // avalon register map, byte addresses
  localparam logic [3:0] REG_CTRL_ADDR   = 4'h0;
  localparam logic [3:0] REG_STATUS_ADDR = 4'h4;
  // ctrl fields
  localparam int unsigned CTRL_WEL_BIT  = 0;
  localparam int unsigned CTRL_LOCK_LO  = 1;
  localparam int unsigned CTRL_LOCK_HI  = 2;
  localparam logic [2:0]  CTRL_RESET    = 3'h0;
  // status fields
  localparam int unsigned STAT_ACTIVE_BIT  = 0;
  localparam int unsigned STAT_HV_BIT      = 1;
  localparam int unsigned STAT_WP_BIT      = 2;
  localparam int unsigned STAT_REFUSED_BIT = 3;
  // write request kinds from the protocol engine
  typedef enum logic [2:0] {
    WPG_WIPER_VOL,
    WPG_WIPER_NV,
    WPG_EEPROM,
    WPG_CTRL_VOL,
    WPG_CTRL_NV
  } wpg_kind_type;
endpackage

module wpg_sync
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic din,
  output var  logic dout
);
  logic meta_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_r <= 1'b0;
      dout   <= 1'b0;
    end
    else
    begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule

`default_nettype wire

/* wpg_gate_chk.sv */
// checker: request answers, locks, nv launch
// assumes bind onto wpg_gate with NV_WRITE_CYCLES of 9 or more
`timescale 1ns/100ps
`default_nettype none
module wpg_gate_chk
(
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  req_valid,
  input wire wpg_pkg::wpg_kind_type req_kind,
  input wire logic                  wel_r,
  input wire logic [1:0]            lock_r,
  input wire logic                  req_grant_r,
  input wire logic                  req_refuse_r,
  input wire logic                  hv_start_r,
  input wire logic                  hv_busy_r,
  input wire logic                  active_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  AST_ONE_ANSWER: assert property (req_valid |=> req_grant_r != req_refuse_r)
    else $error("request answer not exactly one of grant or refuse");
  AST_QUIET: assert property (!req_valid |=> !req_grant_r && !req_refuse_r)
    else $error("answer without request");
  AST_NO_WEL: assert property (req_valid && !wel_r |=> req_refuse_r)
    else $error("write granted with enable latch clear");
  AST_WIPER_LOCK: assert property (req_valid && lock_r != 2'h0 &&
    req_kind <= wpg_pkg::WPG_WIPER_NV |=> req_refuse_r)
    else $error("wiper write granted under lock");
  AST_CTRL_VOL: assert property (req_valid && wel_r &&
    req_kind == wpg_pkg::WPG_CTRL_VOL |=> req_grant_r)
    else $error("volatile control write refused");
  AST_LOCK_ALL: assert property (req_valid && lock_r == 2'h3 &&
    req_kind == wpg_pkg::WPG_EEPROM |=> req_refuse_r)
    else $error("array write granted under full lock");
  AST_HV_HOLD: assert property (hv_start_r |=> hv_busy_r [*8])
    else $error("nv write cycle ended early");
  AST_BUSY_ACT: assert property (hv_busy_r |-> active_r)
    else $error("standby during nv write");
endmodule

bind wpg_gate wpg_gate_chk u_chk (.clk(clk), .rst(rst), .req_valid(req_valid),
  .req_kind(req_kind), .wel_r(wel_r), .lock_r(lock_r), .req_grant_r(req_grant_r),
  .req_refuse_r(req_refuse_r), .hv_start_r(hv_start_r), .hv_busy_r(hv_busy_r),
  .active_r(active_r));
`default_nettype wire

/* wpg_master.sv */
// partner: two-wire bus master, bit-banged from clk
// assumes 4 clk cycles per scl phase; sda held low inside frames
`timescale 1ns/100ps
`default_nettype none
module wpg_master
(
  input  wire logic clk,
  output var  logic scl,
  output var  logic sda
);
  ////////////////////////////////////////
  initial
  begin
    scl = 1'h1;
    sda = 1'h1;
  end
  // phases one cycle above the 3-flop pin latency
  task hold;
    repeat (4) @(posedge clk);
  endtask
  task start;
    if (scl == 1'h0)
    begin
      // repeated start: sda rises while scl is low, so no stop is seen
      sda <= 1'h1;
      hold;
      scl <= 1'h1;
      hold;
    end
    sda <= 1'h0;
    hold;
    scl <= 1'h0;
    hold;
  endtask
  task clocks(input int n);
    repeat (n)
    begin
      scl <= 1'h1;
      hold;
      scl <= 1'h0;
      hold;
    end
  endtask
  task stop;
    scl <= 1'h1;
    hold;
    sda <= 1'h1;
    hold;
  endtask
endmodule
`default_nettype wire

/* write_permission_gate_test.sv */
// bench: permission table, standby timing, nv launch
// assumes wpg_master drives the two-wire pins
`timescale 1ns/100ps
`default_nettype none
module write_permission_gate_test;
  logic                  clk, rst, scl, sda, wp, am, rv, ar, aw;
  logic                  gr, rf, act, hs, hb, write_enable_latch, ws;
  wpg_pkg::wpg_kind_type rk;
  logic [7:0]            ra, rdat;
  logic [3:0]            aa;
  logic [1:0]            lk;
  logic [31:0]           ad, rd, q;
  int                    bad_count = 0;
  int                    tests_run = 0;
  int                    cyc = 0;
  wpg_gate #(.NV_WRITE_CYCLES(50)) u_wpg_gate
  (
    .clk(clk), .rst(rst), .scl_pin(scl), .sda_pin(sda), .wp_pin(wp),
    .addr_match(am), .req_valid(rv), .req_kind(rk), .req_addr(ra),
    .req_data(rdat), .req_grant_r(gr), .req_refuse_r(rf), .active_r(act),
    .hv_start_r(hs), .hv_busy_r(hb), .wel_r(write_enable_latch), .lock_r(lk),
    .avs_address(aa), .avs_read(ar), .avs_write(aw), .avs_writedata(ad),
    .avs_readdata(rd), .avs_waitrequest(ws)
  );
  wpg_master u_wpg_master (.clk(clk), .scl(scl), .sda(sda));
  ////////////////////////////////////////
  task chk(input string n, input logic [31:0] g, e);
    tests_run++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    aa <= a;
    ad <= d;
    ar <= !w;
    aw <= w;
    do @(posedge clk); while (ws !== 1'h0);
    q = rd;
    ar <= 1'h0;
    aw <= 1'h0;
  endtask
  task req(input int k, input logic [7:0] a);
    @(posedge clk);
    rv <= 1'h1;
    rk <= wpg_pkg::wpg_kind_type'(k);
    ra <= a;
    @(posedge clk);
    rv <= 1'h0;
    @(posedge clk);
  endtask
  task match;
    repeat (4) @(posedge clk);
    am <= 1'h1;
    @(posedge clk);
    am <= 1'h0;
  endtask
  ////////////////////////////////////////
  task t_regs;
    @(posedge clk);
    chk("reset", {ws, act, write_enable_latch, lk, hb}, 6'h20);
    req(3, 8'h00);
    chk("refuse", rf, 1'h1);
    bus(1'h1, 4'h4, 32'hf);
    bus(1'h0, 4'h4, 32'h0);
    chk("status", q, 32'h8);
    bus(1'h1, 4'h8, 32'h7);
    bus(1'h0, 4'h8, 32'h0);
    chk("unmapped", q, 32'h0);
    $display("t_regs done");
  endtask
  task t_perm;
    logic [1:0] l;
    logic       g;
    for (int i = 0; i < 8; i++)
    begin
      l = i[2:1];
      bus(1'h1, 4'h0, {29'h0, l, 1'h1});
      bus(1'h0, 4'h0, 32'h0);
      chk("ctrl", q, {29'h0, l, 1'h1});
      wp <= i[0];
      match;
      // flipped pin after sampling must not count
      wp <= !i[0];
      for (int k = 0; k < 6; k++)
      begin
        case (k)
          0: g = l == 2'h0;
          1: g = l == 2'h0 && !i[0];
          2: g = l < 2'h2 && !i[0];
          3: g = 1'h1;
          4: g = !i[0];
          default: g = l == 2'h0 && !i[0];
        endcase
        req(k == 5 ? 2 : k, k == 5 ? 8'hc0 : 8'hbf);
        chk("grant", gr, g);
      end
    end
    bus(1'h1, 4'h0, 32'h1);
    // a granted volatile control write with bit0 low clears the latch
    rdat <= 8'h00;
    req(3, 8'h00);
    chk("wel_clear", {gr, write_enable_latch}, 2'h2);
    rdat <= 8'h01;
    bus(1'h1, 4'h0, 32'h1);
    $display("t_perm done");
  endtask
  task t_link;
    logic n;
    u_wpg_master.start;
    chk("wake", act, 1'h1);
    u_wpg_master.clocks(9);
    repeat (4) @(posedge clk);
    chk("nomatch", act, 1'h0);
    u_wpg_master.start;
    match;
    u_wpg_master.clocks(9);
    u_wpg_master.stop;
    repeat (20) @(posedge clk);
    chk("stop_hold", act, 1'h1);
    repeat (10) @(posedge clk);
    chk("stop_idle", act, 1'h0);
    u_wpg_master.start;
    match;
    u_wpg_master.clocks(10);
    req(1, 8'h00);
    u_wpg_master.stop;
    n = 1'h0;
    repeat (40)
    begin
      @(posedge clk);
      n |= hs;
    end
    chk("bad_frame", n, 1'h0);
    u_wpg_master.start;
    match;
    u_wpg_master.clocks(18);
    req(1, 8'h00);
    chk("nv_grant", gr, 1'h1);
    u_wpg_master.stop;
    repeat (40) if (hs !== 1'h1) @(posedge clk);
    chk("launch", hs, 1'h1);
    repeat (30) @(posedge clk);
    chk("busy", {hb, act}, 2'h3);
    while (hb !== 1'h0) @(posedge clk);
    repeat (3) @(posedge clk);
    chk("after_nv", act, 1'h0);
    $display("t_link done");
  endtask
  ////////////////////////////////////////
  initial
  begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  // every test together stays far below this
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      bad_count++;
      tally_and_finish;
    end
  end
  initial
  begin
    rst = 1'h1;
    wp = 1'h0;
    am = 1'h0;
    rv = 1'h0;
    rk = wpg_pkg::WPG_WIPER_VOL;
    ra = 8'h00;
    rdat = 8'h01;
    aa = 4'h0;
    ar = 1'h0;
    aw = 1'h0;
    ad = 32'h0;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    t_regs;
    t_perm;
    t_link;
    tally_and_finish;
  end
endmodule
`default_nettype wire
